// ---- design/hpc_top.sv ----
`timescale 1ns/1ps
module hpc_top
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Analog side events, asynchronous to sys_clk
    input wire logic switch_node_pulse,
    input wire logic system_rail_awake,
    input wire logic open_circuit_voltage_meas,
    // Register access port
    input wire logic [hpc_pkg::ADDR_WIDTH-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [hpc_pkg::REG_WIDTH-1:0] reg_wdata,
    output logic [hpc_pkg::REG_WIDTH-1:0] reg_rdata,
    // Status
    output logic sleep_mode,
    output logic count_valid
);
    hpc_cnt_if cnt_link();

    logic [hpc_pkg::SYNC_STAGES-1:0] pulse_sync;
    logic [hpc_pkg::SYNC_STAGES-1:0] rail_sync;
    logic [hpc_pkg::SYNC_STAGES-1:0] meas_sync;
    logic pulse_last;
    logic meas_last;
    logic [hpc_pkg::REG_WIDTH-1:0] sleep_count_threshold;
    hpc_pkg::hpc_state_type state;
    hpc_pkg::hpc_state_type next_state;

    wire pulse_edge;
    wire meas_edge;
    wire thr_enabled;
    wire thr_reached;
    wire wr_thr;
    wire [hpc_pkg::CNT_WIDTH-1:0] thr_wide;
    wire [hpc_pkg::REG_WIDTH-1:0] harvest_count_low_byte;
    wire [hpc_pkg::REG_WIDTH-1:0] harvest_count_high_byte;
    wire [hpc_pkg::REG_WIDTH-1:0] next_rdata;

    // Bit 0 is the first stage and only feeds bit 1.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pulse_sync <= '0;
            rail_sync <= '0;
            meas_sync <= '0;
        end
        else
        begin
            pulse_sync <= {pulse_sync[0], switch_node_pulse};
            rail_sync <= {rail_sync[0], system_rail_awake};
            meas_sync <= {meas_sync[0], open_circuit_voltage_meas};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pulse_last <= 1'b0;
            meas_last <= 1'b0;
        end
        else
        begin
            pulse_last <= pulse_sync[1];
            meas_last <= meas_sync[1];
        end
    end

    assign pulse_edge = pulse_sync[1] && !pulse_last;
    assign meas_edge = meas_sync[1] && !meas_last;

    // Pulses seen while asleep are dropped, not deferred.
    assign cnt_link.inc = pulse_edge && (state == hpc_pkg::HPC_AWAKE);
    assign cnt_link.clear = meas_edge;

    hpc_counter u_counter
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .cnt(cnt_link)
    );

    assign thr_wide = {{(hpc_pkg::CNT_WIDTH - hpc_pkg::REG_WIDTH){1'b0}}, sleep_count_threshold};
    assign thr_enabled = (sleep_count_threshold != hpc_pkg::SLEEP_THR_RESET);
    assign thr_reached = thr_enabled && (cnt_link.count >= thr_wide);

    // A measurement ends sleep and restarts the count, so it outranks entry.
    always_comb
    begin
        next_state = state;
        unique case (state)
            hpc_pkg::HPC_AWAKE:
            begin
                if (!meas_edge && thr_reached)
                    next_state = hpc_pkg::HPC_SLEEP;
            end
            hpc_pkg::HPC_SLEEP:
            begin
                if (meas_edge)
                    next_state = hpc_pkg::HPC_AWAKE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state <= hpc_pkg::HPC_AWAKE;
        else
            state <= next_state;
    end

    assign wr_thr = reg_wr && (reg_addr == hpc_pkg::ADDR_SLEEP_THR);

    // Only the threshold is writable; writes to the count bytes fall away.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sleep_count_threshold <= hpc_pkg::SLEEP_THR_RESET;
        else if (wr_thr)
            sleep_count_threshold <= reg_wdata;
    end

    assign harvest_count_low_byte = cnt_link.count[hpc_pkg::LOW_LSB +: hpc_pkg::REG_WIDTH];
    assign harvest_count_high_byte = cnt_link.count[hpc_pkg::HIGH_LSB +: hpc_pkg::REG_WIDTH];
    assign next_rdata = (reg_addr == hpc_pkg::ADDR_COUNT_HIGH) ? harvest_count_high_byte :
                        (reg_addr == hpc_pkg::ADDR_COUNT_LOW) ? harvest_count_low_byte :
                        (reg_addr == hpc_pkg::ADDR_SLEEP_THR) ? sleep_count_threshold :
                        hpc_pkg::READ_ZERO;

    // Read data holds between reads so a slow serial shifter can take it.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            reg_rdata <= hpc_pkg::READ_ZERO;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sleep_mode <= 1'b0;
            count_valid <= 1'b0;
        end
        else
        begin
            sleep_mode <= (next_state == hpc_pkg::HPC_SLEEP);
            count_valid <= rail_sync[1];
        end
    end

    property p_low_read;
        @(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == hpc_pkg::ADDR_COUNT_LOW)
            |=> (reg_rdata == $past(cnt_link.count[7:0]));
    endproperty
    a_low_read: assert property (p_low_read) else $error("low count byte read wrong");

    property p_high_read;
        @(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == hpc_pkg::ADDR_COUNT_HIGH)
            |=> (reg_rdata == $past(cnt_link.count[15:8]));
    endproperty
    a_high_read: assert property (p_high_read) else $error("high count byte read wrong");

    property p_ro_write;
        @(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == hpc_pkg::ADDR_COUNT_LOW && !cnt_link.inc && !cnt_link.clear)
            |=> $stable(cnt_link.count);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write changed the count");

    property p_enter_sleep;
        @(posedge sys_clk) disable iff (rst)
        (state == hpc_pkg::HPC_AWAKE && sleep_count_threshold != 8'h00 && !meas_edge
            && cnt_link.count >= {8'h00, sleep_count_threshold}) |=> sleep_mode;
    endproperty
    a_enter_sleep: assert property (p_enter_sleep) else $error("threshold did not sleep");

    property p_full_compare;
        @(posedge sys_clk) disable iff (rst)
        (state == hpc_pkg::HPC_AWAKE && !meas_edge
            && cnt_link.count < {8'h00, sleep_count_threshold}) |=> !sleep_mode;
    endproperty
    a_full_compare: assert property (p_full_compare) else $error("slept below threshold");

    property p_zero_thr;
        @(posedge sys_clk) disable iff (rst)
        (state == hpc_pkg::HPC_AWAKE && sleep_count_threshold == 8'h00) |=> !sleep_mode;
    endproperty
    a_zero_thr: assert property (p_zero_thr) else $error("slept with zero threshold");

    property p_freeze;
        @(posedge sys_clk) disable iff (rst)
        (state == hpc_pkg::HPC_SLEEP && !meas_edge) |=> $stable(cnt_link.count);
    endproperty
    a_freeze: assert property (p_freeze) else $error("count moved in sleep");

    sequence s_meas_seen;
        meas_sync[1] && !meas_last;
    endsequence

    sequence s_restarted;
        !sleep_mode && cnt_link.count == 16'h0000;
    endsequence

    property p_wake_restart;
        @(posedge sys_clk) disable iff (rst)
        s_meas_seen |=> s_restarted;
    endproperty
    a_wake_restart: assert property (p_wake_restart) else $error("measurement no restart");

    property p_valid_follow;
        @(posedge sys_clk) disable iff (rst)
        $rose(rail_sync[1]) |=> count_valid;
    endproperty
    a_valid_follow: assert property (p_valid_follow) else $error("valid flag lagging");
endmodule

// ---- inc/hpc_pkg.sv ----
package hpc_pkg;
    localparam int CNT_WIDTH = 16;
    localparam int REG_WIDTH = 8;
    localparam int ADDR_WIDTH = 8;
    localparam logic [ADDR_WIDTH-1:0] ADDR_COUNT_HIGH = 8'h0A;
    localparam logic [ADDR_WIDTH-1:0] ADDR_COUNT_LOW = 8'h0B;
    localparam logic [ADDR_WIDTH-1:0] ADDR_SLEEP_THR = 8'h0C;
    localparam logic [REG_WIDTH-1:0] SLEEP_THR_RESET = 8'h00;
    localparam logic [REG_WIDTH-1:0] READ_ZERO = 8'h00;
    localparam logic [CNT_WIDTH-1:0] COUNT_RESET = 16'h0000;
    localparam logic [CNT_WIDTH-1:0] COUNT_FULL = 16'hFFFF;
    localparam logic [CNT_WIDTH-1:0] COUNT_ONE = 16'h0001;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 8;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [0:0]
    {
        HPC_AWAKE = 1'b0,
        HPC_SLEEP = 1'b1
    } hpc_state_type;
endpackage

// ---- inc/hpc_cnt_if.sv ----
`timescale 1ns/1ps
interface hpc_cnt_if;
    logic inc;
    logic clear;
    logic [hpc_pkg::CNT_WIDTH-1:0] count;

    modport ctl
    (
        output inc,
        output clear,
        input count
    );
    modport cnt
    (
        input inc,
        input clear,
        output count
    );
endinterface

// ---- design/hpc_counter.sv ----
`timescale 1ns/1ps
module hpc_counter
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Counter link
    hpc_cnt_if.cnt cnt
);
    wire at_full;
    wire [hpc_pkg::CNT_WIDTH-1:0] next_count;

    assign at_full = (cnt.count == hpc_pkg::COUNT_FULL);
    // The clear wins over an increment in the same cycle.
    assign next_count = cnt.clear ? hpc_pkg::COUNT_RESET :
                        (cnt.inc && !at_full) ? cnt.count + hpc_pkg::COUNT_ONE :
                        cnt.count;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cnt.count <= hpc_pkg::COUNT_RESET;
        else
            cnt.count <= next_count;
    end

    property p_saturate;
        @(posedge sys_clk) disable iff (rst)
        (cnt.count == hpc_pkg::COUNT_FULL && !cnt.clear) |=> (cnt.count == hpc_pkg::COUNT_FULL);
    endproperty
    a_saturate: assert property (p_saturate) else $error("count wrapped past full");

    property p_clear;
        @(posedge sys_clk) disable iff (rst)
        cnt.clear |=> (cnt.count == hpc_pkg::COUNT_RESET);
    endproperty
    a_clear: assert property (p_clear) else $error("count not restarted");
endmodule

// ---- verif/hpc_host_model.sv ----
`timescale 1ns/1ps
module hpc_host_model
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [hpc_pkg::ADDR_WIDTH-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [hpc_pkg::REG_WIDTH-1:0] reg_wdata,
    input wire logic [hpc_pkg::REG_WIDTH-1:0] reg_rdata
);
    // Idle data is inverted so a stale value never looks like a live one.
    initial
    begin
        reg_addr = 8'hFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #2;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #2;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// ---- verif/harvest_pulse_counter_sleep_tb.sv ----
`timescale 1ns/1ps
module harvest_pulse_counter_sleep_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic swp = 1'b0;
    logic rail = 1'b0;
    logic ocv = 1'b0;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic sleep_mode;
    logic count_valid;
    logic [7:0] v;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    hpc_top uut
    (
        .sys_clk(sys_clk), .rst(rst), .switch_node_pulse(swp),
        .system_rail_awake(rail), .open_circuit_voltage_meas(ocv),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
        .reg_rdata(rdata), .sleep_mode(sleep_mode), .count_valid(count_valid)
    );
    hpc_host_model host
    (
        .sys_clk(sys_clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata)
    );

    always #12.5 sys_clk = ~sys_clk;

    // The whole run needs about 2000 cycles; the ceiling leaves ample margin.
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, v);
        chk(v, exp);
    endtask

    // Each pulse is three cycles high and four low (three after the last), above the minimum spacing.
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            #2;
            swp = 1'b1;
            repeat (3) @(posedge sys_clk);
            #2;
            swp = 1'b0;
            repeat (3) @(posedge sys_clk);
        end
        // Step off the edge so callers never sample outputs as they launch.
        #2;
    endtask

    task automatic meas();
        @(posedge sys_clk);
        #2;
        ocv = 1'b1;
        repeat (3) @(posedge sys_clk);
        #2;
        ocv = 1'b0;
        repeat (5) @(posedge sys_clk);
        #2;
    endtask

    task automatic test_regs();
        rchk(8'h0A, 8'h00);
        rchk(8'h0B, 8'h00);
        rchk(8'h0C, 8'h00);
        rchk(8'h0D, 8'h00);
        host.wr(8'h0B, 8'h55);
        host.wr(8'h0A, 8'h66);
        rchk(8'h0B, 8'h00);
        rchk(8'h0A, 8'h00);
        host.wr(8'h0C, 8'hA5);
        rchk(8'h0C, 8'hA5);
        host.wr(8'h0C, 8'h00);
    endtask

    task automatic test_valid();
        @(posedge sys_clk);
        #2;
        rail = 1'b0;
        repeat (6) @(posedge sys_clk);
        #2;
        chk({7'h00, count_valid}, 8'h00);
        rail = 1'b1;
        repeat (6) @(posedge sys_clk);
        #2;
        chk({7'h00, count_valid}, 8'h01);
    endtask

    task automatic test_sleep();
        pulse(3);
        rchk(8'h0B, 8'h03);
        chk({7'h00, sleep_mode}, 8'h00);
        host.wr(8'h0C, 8'h05);
        pulse(1);
        chk({7'h00, sleep_mode}, 8'h00);
        pulse(1);
        chk({7'h00, sleep_mode}, 8'h01);
        pulse(2);
        rchk(8'h0B, 8'h05);
        meas();
        chk({7'h00, sleep_mode}, 8'h00);
        rchk(8'h0B, 8'h00);
    endtask

    task automatic test_full();
        host.wr(8'h0C, 8'h00);
        pulse(256);
        rchk(8'h0A, 8'h01);
        rchk(8'h0B, 8'h00);
        chk({7'h00, sleep_mode}, 8'h00);
        host.wr(8'h0C, 8'h01);
        repeat (3) @(posedge sys_clk);
        #2;
        chk({7'h00, sleep_mode}, 8'h01);
        meas();
        chk({7'h00, sleep_mode}, 8'h00);
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        #2;
        rst = 1'b0;
        rail = 1'b1;
        test_regs();
        test_valid();
        test_sleep();
        test_full();
        results();
    end
endmodule
